//--- hw/interval_counter_pkg.sv
package interval_counter_pkg;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_CTL0 = 8'h00;
   localparam logic [7:0] OFS_CTL1 = 8'h04;
   localparam logic [7:0] OFS_CMP0 = 8'h08;
   localparam logic [7:0] OFS_CMP1 = 8'h0c;
   localparam logic [7:0] OFS_CNT = 8'h10;
   localparam logic [7:0] OFS_OPT0 = 8'h14;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CTL0_CE_BIT = 7;
   localparam int CTL0_CKS_LSB = 0;
   localparam int CTL1_MODE_LSB = 0;
   localparam int CTL1_EDGE_LSB = 4;
   localparam int OPT0_OVF_BIT = 0;

   // ****************************************
   // Reset and fixed values
   // ****************************************
   localparam logic [7:0] CTL0_RESET = 8'h00;
   localparam logic [7:0] CTL1_RESET = 8'h00;
   localparam logic [15:0] CMP_RESET = 16'h0000;
   localparam logic [15:0] CNT_IDLE = 16'hffff;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;

   // ****************************************
   // Modes, edges, responses
   // ****************************************
   localparam logic [2:0] MODE_INTERVAL = 3'h0;
   localparam logic [2:0] MODE_EVENT = 3'h1;
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      STOPPED = 3'h1,
      ARMED = 3'h2,
      COUNTING = 3'h4
   } run_state_t;

endpackage

//--- hw/count_tick_if.sv
`timescale 1ns/100ps
interface count_tick_if;
   logic run;
   logic evtMode;
   logic [2:0] clkSel;
   logic [1:0] edgeSel;
   logic tick;

   modport ctrl (output run, output evtMode, output clkSel, output edgeSel, input tick);
   modport gen (input run, input evtMode, input clkSel, input edgeSel, output tick);
endinterface

//--- hw/count_tick_gen.sv
`timescale 1ns/100ps
module count_tick_gen (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // External event pin
   input wire logic eventIn,
   // Tick control
   count_tick_if.gen tk
);

   typedef struct packed {
      logic syncA;
      logic syncB;
      logic prevLvl;
      logic [6:0] div;
      logic tick;
   } gen_t;

   gen_t st_ff;
   gen_t nxt_st;

   // ****************************************
   // Prescaler mask for 2^clkSel
   // ****************************************
   function automatic logic [6:0] divMask(input logic [2:0] sel);
      logic [7:0] one;
      one = 8'h01 << sel;
      return 7'(one - 8'h01);
   endfunction

   always_comb begin
      nxt_st = st_ff;
      nxt_st.syncA = eventIn;
      nxt_st.syncB = st_ff.syncA;
      nxt_st.prevLvl = st_ff.syncB;
      nxt_st.tick = 1'b0;
      if (!tk.run || tk.evtMode) begin
         nxt_st.div = 7'h00;
      end else begin
         nxt_st.div = 7'(st_ff.div + 7'h01);
      end
      if (tk.run && tk.evtMode) begin
         case (tk.edgeSel)
            interval_counter_pkg::EDGE_RISE: nxt_st.tick = st_ff.syncB & ~st_ff.prevLvl;
            interval_counter_pkg::EDGE_FALL: nxt_st.tick = ~st_ff.syncB & st_ff.prevLvl;
            interval_counter_pkg::EDGE_BOTH: nxt_st.tick = st_ff.syncB ^ st_ff.prevLvl;
            default: nxt_st.tick = 1'b0;
         endcase
      end else if (tk.run) begin
         nxt_st.tick = ((st_ff.div & divMask(tk.clkSel)) == divMask(tk.clkSel));
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tk.tick = st_ff.tick;

endmodule

//--- hw/interval_and_event_counter.sv
`timescale 1ns/100ps
module interval_and_event_counter (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // AXI4-Lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   // AXI4-Lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // AXI4-Lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   // AXI4-Lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Event input pin
   input wire logic eventIn,
   // Timer outputs
   output logic primaryTimerOutput,
   output logic secondaryTimerOutput,
   // Interrupt request pulses
   output logic compareZeroMatchIrq,
   output logic compareOneMatchIrq,
   output logic counterOverflowIrq
);

   typedef struct packed {
      interval_counter_pkg::run_state_t fsm;
      logic [7:0] ctl0;
      logic [7:0] ctl1;
      logic [15:0] cmp0Reg;
      logic [15:0] cmp1Reg;
      logic [15:0] cmp0Buf;
      logic [15:0] cmp1Buf;
      logic [15:0] cnt;
      logic ovf;
      logic primOut;
      logic secOut;
      logic irq0;
      logic irq1;
      logic irqOv;
      logic awRdy;
      logic wRdy;
      logic awHave;
      logic wHave;
      logic [7:0] awAddr;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic arRdy;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } core_t;

   core_t st_ff;
   core_t nxt_st;

   logic ce;
   logic [2:0] mode;
   logic validMode;
   logic countTick;
   logic doWrite;
   logic [7:0] wrAddr;
   logic [31:0] wrData;
   logic [3:0] wrStrb;
   logic [31:0] rdWord;
   logic rdOk;

   count_tick_if tk ();

   // ****************************************
   // Helper functions
   // ****************************************
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                           input logic [3:0] strb);
      logic [15:0] res;
      res = old;
      if (strb[0]) begin
         res[7:0] = data[7:0];
      end
      if (strb[1]) begin
         res[15:8] = data[15:8];
      end
      return res;
   endfunction

   function automatic logic isMapped(input logic [7:0] addr);
      return (addr == interval_counter_pkg::OFS_CTL0) || (addr == interval_counter_pkg::OFS_CTL1) ||
             (addr == interval_counter_pkg::OFS_CMP0) || (addr == interval_counter_pkg::OFS_CMP1) ||
             (addr == interval_counter_pkg::OFS_CNT) || (addr == interval_counter_pkg::OFS_OPT0);
   endfunction

   // ****************************************
   // Tick source
   // ****************************************
   assign ce = st_ff.ctl0[interval_counter_pkg::CTL0_CE_BIT];
   assign mode = st_ff.ctl1[interval_counter_pkg::CTL1_MODE_LSB +: 3];
   assign validMode = (mode == interval_counter_pkg::MODE_INTERVAL) || (mode == interval_counter_pkg::MODE_EVENT);
   assign tk.run = ce;
   assign tk.evtMode = (mode == interval_counter_pkg::MODE_EVENT);
   assign tk.clkSel = st_ff.ctl0[interval_counter_pkg::CTL0_CKS_LSB +: 3];
   assign tk.edgeSel = st_ff.ctl1[interval_counter_pkg::CTL1_EDGE_LSB +: 2];
   assign countTick = tk.tick;

   count_tick_gen tickGen (
      .clock(clock),
      .rst_n(rst_n),
      .eventIn(eventIn),
      .tk(tk)
   );

   // ****************************************
   // Bus side decode
   // ****************************************
   always_comb begin
      doWrite = 1'b0;
      wrAddr = st_ff.awHave ? st_ff.awAddr : s_axi_awaddr;
      wrData = st_ff.wHave ? st_ff.wData : s_axi_wdata;
      wrStrb = st_ff.wHave ? st_ff.wStrb : s_axi_wstrb;
      if ((st_ff.awHave || (s_axi_awvalid && st_ff.awRdy)) && (st_ff.wHave || (s_axi_wvalid && st_ff.wRdy))) begin
         doWrite = 1'b1;
      end
   end

   always_comb begin
      rdWord = 32'h0000_0000;
      rdOk = 1'b1;
      case (s_axi_araddr)
         interval_counter_pkg::OFS_CTL0: rdWord[7:0] = st_ff.ctl0;
         interval_counter_pkg::OFS_CTL1: rdWord[7:0] = st_ff.ctl1;
         interval_counter_pkg::OFS_CMP0: rdWord[15:0] = st_ff.cmp0Reg;
         interval_counter_pkg::OFS_CMP1: rdWord[15:0] = st_ff.cmp1Reg;
         interval_counter_pkg::OFS_CNT: rdWord[15:0] = ce ? st_ff.cnt : interval_counter_pkg::CNT_ZERO;
         interval_counter_pkg::OFS_OPT0: rdWord[interval_counter_pkg::OPT0_OVF_BIT] = st_ff.ovf;
         default: rdOk = 1'b0;
      endcase
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      nxt_st = st_ff;
      nxt_st.irq0 = 1'b0;
      nxt_st.irq1 = 1'b0;
      nxt_st.irqOv = 1'b0;

      // Write channel: address and data taken in either order
      if (st_ff.awRdy && s_axi_awvalid) begin
         nxt_st.awHave = 1'b1;
         nxt_st.awAddr = s_axi_awaddr;
      end
      if (st_ff.wRdy && s_axi_wvalid) begin
         nxt_st.wHave = 1'b1;
         nxt_st.wData = s_axi_wdata;
         nxt_st.wStrb = s_axi_wstrb;
      end
      if (st_ff.bValid && s_axi_bready) begin
         nxt_st.bValid = 1'b0;
      end
      if (doWrite) begin
         nxt_st.awHave = 1'b0;
         nxt_st.wHave = 1'b0;
         nxt_st.bValid = 1'b1;
         nxt_st.bResp = isMapped(wrAddr) ? interval_counter_pkg::RESP_OKAY : interval_counter_pkg::RESP_SLVERR;
         case (wrAddr)
            interval_counter_pkg::OFS_CTL0: begin
               if (wrStrb[0]) begin
                  nxt_st.ctl0 = wrData[7:0];
               end
            end
            interval_counter_pkg::OFS_CTL1: begin
               if (wrStrb[0]) begin
                  nxt_st.ctl1 = wrData[7:0];
               end
            end
            interval_counter_pkg::OFS_CMP0: begin
               nxt_st.cmp0Reg = merge16(st_ff.cmp0Reg, wrData, wrStrb);
               nxt_st.cmp0Buf = merge16(st_ff.cmp0Reg, wrData, wrStrb);
            end
            interval_counter_pkg::OFS_CMP1: begin
               nxt_st.cmp1Reg = merge16(st_ff.cmp1Reg, wrData, wrStrb);
               nxt_st.cmp1Buf = merge16(st_ff.cmp1Reg, wrData, wrStrb);
            end
            interval_counter_pkg::OFS_OPT0: begin
               if (wrStrb[0]) begin
                  nxt_st.ovf = wrData[interval_counter_pkg::OPT0_OVF_BIT];
               end
            end
            default: begin
            end
         endcase
      end
      nxt_st.awRdy = !nxt_st.awHave && !nxt_st.bValid;
      nxt_st.wRdy = !nxt_st.wHave && !nxt_st.bValid;

      // Read channel
      if (st_ff.rValid && s_axi_rready) begin
         nxt_st.rValid = 1'b0;
      end
      if (st_ff.arRdy && s_axi_arvalid) begin
         nxt_st.rValid = 1'b1;
         nxt_st.rData = rdWord;
         nxt_st.rResp = rdOk ? interval_counter_pkg::RESP_OKAY : interval_counter_pkg::RESP_SLVERR;
      end
      nxt_st.arRdy = !nxt_st.rValid;

      // Counter; hardware set of the overflow flag follows the bus write
      if (!ce) begin
         nxt_st.fsm = interval_counter_pkg::STOPPED;
         nxt_st.cnt = interval_counter_pkg::CNT_IDLE;
      end else begin
         case (st_ff.fsm)
            interval_counter_pkg::STOPPED: begin
               nxt_st.fsm = interval_counter_pkg::ARMED;
               nxt_st.cmp0Buf = nxt_st.cmp0Reg;
               nxt_st.cmp1Buf = nxt_st.cmp1Reg;
            end
            interval_counter_pkg::ARMED: begin
               if (mode == interval_counter_pkg::MODE_EVENT) begin
                  // Start wrap, no event needed
                  nxt_st.cnt = interval_counter_pkg::CNT_ZERO;
                  nxt_st.fsm = interval_counter_pkg::COUNTING;
                  if (st_ff.cmp0Buf == interval_counter_pkg::CNT_ZERO) begin
                     nxt_st.irq0 = 1'b1;
                  end
                  if (st_ff.cmp1Buf == interval_counter_pkg::CNT_ZERO) begin
                     nxt_st.irq1 = 1'b1;
                     nxt_st.secOut = ~st_ff.secOut;
                  end
               end else if (mode == interval_counter_pkg::MODE_INTERVAL && countTick) begin
                  nxt_st.cnt = interval_counter_pkg::CNT_ZERO;
                  nxt_st.primOut = ~st_ff.primOut;
                  nxt_st.fsm = interval_counter_pkg::COUNTING;
               end
            end
            interval_counter_pkg::COUNTING: begin
               if (countTick && validMode) begin
                  if (st_ff.cnt == st_ff.cmp0Buf) begin
                     // Match clears, covers all-ones without overflow
                     nxt_st.cnt = interval_counter_pkg::CNT_ZERO;
                     nxt_st.irq0 = 1'b1;
                     if (mode == interval_counter_pkg::MODE_INTERVAL) begin
                        nxt_st.primOut = ~st_ff.primOut;
                     end
                  end else if (st_ff.cnt == interval_counter_pkg::CNT_IDLE) begin
                     // Buffer lowered below count
                     nxt_st.cnt = interval_counter_pkg::CNT_ZERO;
                     nxt_st.ovf = 1'b1;
                     nxt_st.irqOv = 1'b1;
                  end else begin
                     nxt_st.cnt = st_ff.cnt + interval_counter_pkg::CNT_ONE;
                  end
                  if (st_ff.cnt == st_ff.cmp1Buf) begin
                     nxt_st.irq1 = 1'b1;
                     nxt_st.secOut = ~st_ff.secOut;
                  end
               end
            end
            default: begin
               nxt_st.fsm = interval_counter_pkg::STOPPED;
            end
         endcase
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
         st_ff.fsm <= interval_counter_pkg::STOPPED;
         st_ff.ctl0 <= interval_counter_pkg::CTL0_RESET;
         st_ff.ctl1 <= interval_counter_pkg::CTL1_RESET;
         st_ff.cmp0Reg <= interval_counter_pkg::CMP_RESET;
         st_ff.cmp1Reg <= interval_counter_pkg::CMP_RESET;
         st_ff.cmp0Buf <= interval_counter_pkg::CMP_RESET;
         st_ff.cmp1Buf <= interval_counter_pkg::CMP_RESET;
         st_ff.cnt <= interval_counter_pkg::CNT_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign s_axi_awready = st_ff.awRdy;
   assign s_axi_wready = st_ff.wRdy;
   assign s_axi_bvalid = st_ff.bValid;
   assign s_axi_bresp = st_ff.bResp;
   assign s_axi_arready = st_ff.arRdy;
   assign s_axi_rvalid = st_ff.rValid;
   assign s_axi_rdata = st_ff.rData;
   assign s_axi_rresp = st_ff.rResp;
   assign primaryTimerOutput = st_ff.primOut;
   assign secondaryTimerOutput = st_ff.secOut;
   assign compareZeroMatchIrq = st_ff.irq0;
   assign compareOneMatchIrq = st_ff.irq1;
   assign counterOverflowIrq = st_ff.irqOv;

endmodule

//--- test/interval_and_event_counter_sva.sv
`timescale 1ns/100ps
module interval_and_event_counter_sva (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   // Secondary timer output and requests
   input wire logic secondaryTimerOutput,
   input wire logic compareZeroMatchIrq,
   input wire logic compareOneMatchIrq,
   input wire logic counterOverflowIrq
);
   logic countEnable_ff;
   logic wrTaken;
   assign wrTaken = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   // Count enable as last written
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         countEnable_ff <= 1'b0;
      end else if (wrTaken && s_axi_awaddr == interval_counter_pkg::OFS_CTL0) begin
         countEnable_ff <= s_axi_wdata[interval_counter_pkg::CTL0_CE_BIT];
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   a_write_answer:
      assert property (wrTaken |=> s_axi_bvalid && !s_axi_awready) else $error("write not answered");
   a_bresp_hold:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_answer:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered");
   a_rdata_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_read_unmapped:
      assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h18
         |=> s_axi_rresp == interval_counter_pkg::RESP_SLVERR) else $error("unmapped read not refused");
   a_idle_count_zero:
      assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == interval_counter_pkg::OFS_CNT
         && !countEnable_ff |=> s_axi_rdata == 32'h0) else $error("idle count not zero");
   a_sec_toggles:
      assert property (compareOneMatchIrq |-> secondaryTimerOutput != $past(secondaryTimerOutput))
      else $error("secondary output missed toggle");
   a_sec_cause:
      assert property ($changed(secondaryTimerOutput) |-> compareOneMatchIrq) else $error("stray toggle");
   a_ovf_apart:
      assert property (counterOverflowIrq |-> !compareZeroMatchIrq ##1 !counterOverflowIrq)
      else $error("overflow with match");
   a_irq_when_run:
      assert property (compareZeroMatchIrq || compareOneMatchIrq || counterOverflowIrq
         |-> countEnable_ff || $past(countEnable_ff)) else $error("request while stopped");
endmodule

bind interval_and_event_counter interval_and_event_counter_sva chk (.clock(clock), .rst_n(rst_n),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .secondaryTimerOutput(secondaryTimerOutput),
   .compareZeroMatchIrq(compareZeroMatchIrq), .compareOneMatchIrq(compareOneMatchIrq),
   .counterOverflowIrq(counterOverflowIrq));

//--- test/tb_interval_and_event_counter.sv
`timescale 1ns/100ps
module tb_interval_and_event_counter;
   logic clock = 1'b0, rst_n = 1'b0, eventIn = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdVal;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic primaryTimerOutput, secondaryTimerOutput, compareZeroMatchIrq, compareOneMatchIrq, counterOverflowIrq;
   logic p0;
   int errorCnt = 0, cmpCount = 0, irq0Cnt = 0, irq1Cnt = 0, ovfCnt = 0;
   int gap0 = 0, gap1 = 0, since0 = 0, since1 = 0, b0, b1, bo;

   interval_and_event_counter uut (.clock(clock), .rst_n(rst_n),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awprot(3'h0), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .eventIn(eventIn), .primaryTimerOutput(primaryTimerOutput),
      .secondaryTimerOutput(secondaryTimerOutput), .compareZeroMatchIrq(compareZeroMatchIrq),
      .compareOneMatchIrq(compareOneMatchIrq), .counterOverflowIrq(counterOverflowIrq));

   always #12.5 clock = ~clock;

   // **************************************
   // Request counters and spacing
   // **************************************
   always @(posedge clock) begin
      since0++;
      since1++;
      if (compareZeroMatchIrq === 1'b1) begin
         irq0Cnt++;
         gap0 = since0;
         since0 = 0;
      end
      if (compareOneMatchIrq === 1'b1) begin
         irq1Cnt++;
         gap1 = since1;
         since1 = 0;
      end
      if (counterOverflowIrq === 1'b1) begin
         ovfCnt++;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         errorCnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      logic awPend;
      logic wPend;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      awPend = 1'b1;
      wPend = 1'b1;
      forever begin
         @(posedge clock);
         if (s_axi_bready && s_axi_bvalid) break;
         if (!awPend && !wPend) s_axi_bready <= 1'b1;
         if (awPend && s_axi_awready) begin
            awPend = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (wPend && s_axi_wready) begin
            wPend = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(er));
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'h0);
      logic arPend;
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      arPend = 1'b1;
      forever begin
         @(posedge clock);
         if (s_axi_rready && s_axi_rvalid) break;
         if (!arPend) s_axi_rready <= 1'b1;
         if (arPend && s_axi_arready) begin
            arPend = 1'b0;
            s_axi_arvalid <= 1'b0;
         end
      end
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
      chk(32'(s_axi_rresp), 32'(er));
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd(a, v);
      chk(v, exp);
   endtask

   // Event pin pulses, then room for the synchroniser
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clock);
         eventIn <= 1'b1;
         repeat (4) @(posedge clock);
         eventIn <= 1'b0;
         repeat (4) @(posedge clock);
      end
      repeat (6) @(posedge clock);
   endtask

   task automatic endOfTest();
      if (errorCnt == 0 && cmpCount > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      repeat (80000) @(posedge clock);
      errorCnt++;
      endOfTest();
   end

   initial begin
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      for (int i = 0; i < 6; i++) rc(8'(i * 4), 32'h0);
      rd(8'h18, rdVal, interval_counter_pkg::RESP_SLVERR);
      wr(8'h18, 32'h0, interval_counter_pkg::RESP_SLVERR);
      // Interval mode, compare-0 4, compare-1 2
      wr(interval_counter_pkg::OFS_CMP0, 32'h4);
      wr(interval_counter_pkg::OFS_CMP1, 32'h2);
      p0 = primaryTimerOutput;
      wr(interval_counter_pkg::OFS_CTL0, 32'h80);
      repeat (3) @(posedge clock);
      chk(32'(primaryTimerOutput), 32'(!p0));
      repeat (30) @(posedge clock);
      chk(32'(gap0), 32'h5);
      chk(32'(gap1), 32'h5);
      rd(interval_counter_pkg::OFS_CNT, rdVal);
      chk(32'(rdVal < 32'h5), 32'h1);
      rc(interval_counter_pkg::OFS_CTL0, 32'h80);
      wr(interval_counter_pkg::OFS_CMP1, 32'h9);
      b1 = irq1Cnt;
      p0 = secondaryTimerOutput;
      repeat (30) @(posedge clock);
      chk(32'(irq1Cnt - b1), 32'h0);
      chk(32'(secondaryTimerOutput), 32'(p0));
      // Compare-0 lowered below a running count
      wr(interval_counter_pkg::OFS_CMP0, 32'd100);
      b0 = irq0Cnt;
      while (irq0Cnt == b0) @(posedge clock);
      repeat (60) @(posedge clock);
      bo = ovfCnt;
      b0 = irq0Cnt;
      wr(interval_counter_pkg::OFS_CMP0, 32'd40);
      while (irq0Cnt == b0) @(posedge clock);
      @(posedge clock);
      chk(32'(gap0), 32'h10029);
      chk(32'(ovfCnt - bo), 32'h1);
      rc(interval_counter_pkg::OFS_OPT0, 32'h1);
      wr(interval_counter_pkg::OFS_OPT0, 32'h0);
      rc(interval_counter_pkg::OFS_OPT0, 32'h0);
      // Compare-0 zero, stopped first
      wr(interval_counter_pkg::OFS_CTL0, 32'h0);
      wr(interval_counter_pkg::OFS_CMP0, 32'h0);
      wr(interval_counter_pkg::OFS_CTL0, 32'h80);
      repeat (10) @(posedge clock);
      chk(32'(gap0), 32'h1);
      rc(interval_counter_pkg::OFS_CNT, 32'h0);
      // Prescale by four: one tick every four clocks
      wr(interval_counter_pkg::OFS_CTL0, 32'h82);
      repeat (20) @(posedge clock);
      chk(32'(gap0), 32'h4);
      // Event mode, rising edge
      wr(interval_counter_pkg::OFS_CTL0, 32'h0);
      rc(interval_counter_pkg::OFS_CNT, 32'h0);
      wr(interval_counter_pkg::OFS_CTL1, 32'h11);
      wr(interval_counter_pkg::OFS_CMP0, 32'h2);
      wr(interval_counter_pkg::OFS_CMP1, 32'h0);
      p0 = primaryTimerOutput;
      b0 = irq0Cnt;
      b1 = irq1Cnt;
      wr(interval_counter_pkg::OFS_CTL0, 32'h80);
      repeat (4) @(posedge clock);
      chk(32'(irq1Cnt - b1), 32'h1);
      chk(32'(irq0Cnt - b0), 32'h0);
      pulses(2);
      rc(interval_counter_pkg::OFS_CNT, 32'h2);
      pulses(1);
      chk(32'(irq0Cnt - b0), 32'h1);
      rc(interval_counter_pkg::OFS_CNT, 32'h0);
      chk(32'(primaryTimerOutput), 32'(p0));
      wr(interval_counter_pkg::OFS_CTL0, 32'h0);
      wr(interval_counter_pkg::OFS_CMP0, 32'h0);
      b0 = irq0Cnt;
      wr(interval_counter_pkg::OFS_CTL0, 32'h80);
      repeat (4) @(posedge clock);
      pulses(3);
      chk(32'(irq0Cnt - b0), 32'h4);
      rc(interval_counter_pkg::OFS_CNT, 32'h0);
      // Falling edge only
      wr(interval_counter_pkg::OFS_CTL1, 32'h21);
      b0 = irq0Cnt;
      pulses(2);
      chk(32'(irq0Cnt - b0), 32'h2);
      endOfTest();
   end
endmodule
